// File: hw/ntpis_pkg.sv
/*
  Constants for the host-side two-plane NAND sequencer: command codes,
  pin timing counts, identification byte layout and operation encodings.
  Assumes a 10 MHz reference clock and an 8-bit asynchronous NAND device.
*/
// Summary of operation
// - Two-plane operations use mirrored pages
// - Program rows differ only in plane bit
// - Only status or reset between 11h, 81h
// - Read: 60h plus row, twice, then 30h
// - Read same page, same block position
// - Per plane: 00h, 05h columns, E0h readout
// - Two-plane read only on two-plane programs
// - Last cache read pages use 3Fh
// - Copy-back stays inside one plane
`default_nettype none
package ntpis_pkg;
  // ==========================================================
  // Command codes
  localparam logic [7:0] CMD_READ1 = 8'h00;
  localparam logic [7:0] CMD_READ2 = 8'h30;
  localparam logic [7:0] CMD_RDCOL = 8'h05;
  localparam logic [7:0] CMD_RDCOL2 = 8'hE0;
  localparam logic [7:0] CMD_PROG1 = 8'h80;
  localparam logic [7:0] CMD_PROG2 = 8'h81;
  localparam logic [7:0] CMD_PDUMMY = 8'h11;
  localparam logic [7:0] CMD_PCONF = 8'h10;
  localparam logic [7:0] CMD_ERASE1 = 8'h60;
  localparam logic [7:0] CMD_ERASE2 = 8'hD0;
  localparam logic [7:0] CMD_CACHE_LOAD = 8'h33;
  localparam logic [7:0] CMD_CACHE_NEXT = 8'h31;
  localparam logic [7:0] CMD_CACHE_END = 8'h3F;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_IDREAD = 8'h90;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  // ==========================================================
  // Timing, at 10 MHz
  localparam int CLK_NS = 100;
  localparam int ARRAY_READ_TIME_US = 30;
  localparam int CACHE_BUSY_TIME_US = 35;
  localparam int WB_NS = 100;
  localparam int ARRAY_READ_CYC = ARRAY_READ_TIME_US * 1000 / CLK_NS;
  localparam int CACHE_BUSY_CYC = CACHE_BUSY_TIME_US * 1000 / CLK_NS;
  localparam int WB_CYC = (WB_NS + CLK_NS - 1) / CLK_NS;
  localparam int ID_BYTES = 10;
  localparam int PAGE_BYTES = 4314;
  // ==========================================================
  // Status and identification fields
  localparam int ST_FAIL_BIT = 0;
  localparam int ST_READY_BIT = 6;
  localparam int ID3_CHIPS_LSB = 0;
  localparam int ID3_LEVELS_LSB = 2;
  localparam int ID3_PAGES_LSB = 4;
  localparam int ID3_INTERLEAVE_BIT = 6;
  localparam int ID3_CACHEPROG_BIT = 7;
  localparam int ID5_PLANES_LSB = 2;
  localparam int ID5_ECC_LSB = 4;
  localparam int ID6_PROC_LSB = 0;
  localparam int ID6_EXTOUT_BIT = 6;
  localparam int ID6_DDR_BIT = 7;
  // Operation requests from the user side
  typedef enum logic [2:0] {
    NTPIS_OP_PROG2, NTPIS_OP_ERASE2, NTPIS_OP_READ2, NTPIS_OP_CACHE2,
    NTPIS_OP_STATUS, NTPIS_OP_ID, NTPIS_OP_RESET, NTPIS_OP_COPY2
  } ntpis_op_t;
endpackage
`default_nettype wire

// File: hw/ntpis_host.sv
/*
  Host controller for two-plane NAND operations and ID readout.
  Assumes the device pins are synchronous to ref_clk; each strobe phase
  lasts one clock (100 ns), well over the minimum pulse widths.
*/
`timescale 1ns/100ps
`default_nettype none
module ntpis_host #(
  parameter int COUNT_W = 16
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  // User side
  input wire logic op_valid,
  input wire ntpis_pkg::ntpis_op_t op_code,
  input wire logic [23:0] op_row,
  input wire logic [15:0] op_len,
  input wire logic op_last,
  output logic op_ready,
  input wire logic [7:0] wr_data,
  output logic wr_take,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic [3:0] rd_index,
  output logic op_done,
  output logic op_fail,
  output logic [7:0] id_byte3,
  output logic [7:0] id_byte4,
  output logic [7:0] id_byte5,
  output logic [7:0] id_byte6,
  // Device pins
  output logic chip_en_n,
  output logic cmd_latch,
  output logic addr_latch,
  output logic write_strobe_n,
  output logic read_strobe_n,
  output logic [7:0] io_out,
  output logic io_oe,
  input wire logic [7:0] io_in,
  input wire logic ready_busy_n
);
  import ntpis_pkg::*;

  typedef enum {S_IDLE, S_PUT, S_GET, S_WAIT, S_DONE} ntpis_state_t;
  // One step of the pin sequence
  typedef enum logic [1:0] {K_CMD, K_ADDR, K_DATA, K_READ} ntpis_kind_t;

  ntpis_state_t state;
  ntpis_op_t op;
  logic [5:0] step;
  logic phase;
  logic [COUNT_W-1:0] cnt;
  logic [23:0] row;
  logic [15:0] len;
  logic last;
  logic [1:0] plane;
  logic wait_seen;
  logic [COUNT_W-1:0] wait_cnt;

  // ==========================================================
  // Sequence table: kind, byte, end and busy flags for each op and step
  ntpis_kind_t kind;
  logic [7:0] code;
  logic seq_end;
  logic busy_after;
  logic [23:0] row_p;

  // Plane-select bit is row bit 7 (address bit A20)
  // one row for both halves, so pages mirror
  always_comb begin
    row_p = {row[23:8], plane[0], row[6:0]};
  end

  always_comb begin
    kind = K_CMD;
    code = CMD_STATUS;
    seq_end = 1'b0;
    busy_after = 1'b0;
    case (op)
      NTPIS_OP_PROG2, NTPIS_OP_COPY2: begin
        case (step)
          6'd0: code = (plane[0]) ? CMD_PROG2 : CMD_PROG1;
          6'd1, 6'd2: begin
            kind = K_ADDR;
            code = 8'h00;
          end
          // same row, plane bit only differs
          6'd3: begin kind = K_ADDR; code = row_p[7:0]; end
          6'd4: begin kind = K_ADDR; code = row_p[15:8]; end
          6'd5: begin kind = K_ADDR; code = row_p[23:16]; end
          6'd6: kind = K_DATA;
          default: begin
            code = (plane[0]) ? CMD_PCONF : CMD_PDUMMY;
            seq_end = 1'b1;
            busy_after = 1'b1;
          end
        endcase
      end
      // two-plane erase, read and cache: 60h row twice, then D0h, 30h or 33h
      NTPIS_OP_ERASE2, NTPIS_OP_READ2, NTPIS_OP_CACHE2: begin
        case (step)
          6'd0, 6'd4: code = CMD_ERASE1;
          6'd1, 6'd5: begin kind = K_ADDR; code = row_p[7:0]; end
          6'd2, 6'd6: begin kind = K_ADDR; code = row_p[15:8]; end
          6'd3, 6'd7: begin kind = K_ADDR; code = row_p[23:16]; end
          6'd8: begin
            code = (op == NTPIS_OP_ERASE2) ? CMD_ERASE2 :
                   (op == NTPIS_OP_READ2) ? CMD_READ2 : CMD_CACHE_LOAD;
            seq_end = 1'b1;
            busy_after = 1'b1;
          end
          default: begin
            // final cached pages end with 3Fh, others 31h
            code = (last) ? CMD_CACHE_END : CMD_CACHE_NEXT;
            seq_end = 1'b1;
            busy_after = 1'b1;
          end
        endcase
      end
      NTPIS_OP_ID: begin
        case (step)
          6'd0: code = CMD_IDREAD;
          6'd1: begin kind = K_ADDR; code = 8'h00; end
          default: begin kind = K_READ; seq_end = 1'b1; end
        endcase
      end
      NTPIS_OP_RESET: begin
        code = CMD_RESET;
        seq_end = 1'b1;
        busy_after = 1'b1;
      end
      default: begin
        if (step == 6'd0) begin
          code = CMD_STATUS;
        end else begin
          kind = K_READ;
          seq_end = 1'b1;
        end
      end
    endcase
  end

  // Readout sequence for two-plane read and cache, used after busy ends
  // 00h, five addresses, 05h, two columns, E0h
  logic [7:0] rd_code;
  ntpis_kind_t rd_kind;
  always_comb begin
    rd_kind = K_ADDR;
    rd_code = 8'h00;
    case (step)
      6'd0: begin rd_kind = K_CMD; rd_code = CMD_READ1; end
      6'd3: rd_code = row_p[7:0];
      6'd4: rd_code = row_p[15:8];
      6'd5: rd_code = row_p[23:16];
      6'd6: begin rd_kind = K_CMD; rd_code = CMD_RDCOL; end
      6'd9: begin rd_kind = K_CMD; rd_code = CMD_RDCOL2; end
      6'd10: rd_kind = K_READ;
      default: rd_code = 8'h00;
    endcase
  end

  logic in_readout;
  ntpis_kind_t cur_kind;
  logic [7:0] cur_code;
  always_comb begin
    cur_kind = (in_readout) ? rd_kind : kind;
    cur_code = (in_readout) ? rd_code : code;
  end

  logic need_len;
  assign need_len = (cur_kind == K_DATA) || (cur_kind == K_READ);
  assign op_ready = (state == S_IDLE);
  assign wr_take = (state == S_PUT) && phase && (cur_kind == K_DATA);

  // ==========================================================
  // Main sequencer, two clocks per bus cycle (strobe low, high)
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= S_IDLE;
      op <= NTPIS_OP_STATUS;
      step <= 6'd0;
      phase <= 1'b0;
      cnt <= '0;
      row <= 24'h00_0000;
      len <= 16'h0000;
      last <= 1'b0;
      plane <= 2'd0;
      in_readout <= 1'b0;
      wait_seen <= 1'b0;
      wait_cnt <= '0;
    end else begin
      case (state)
        S_IDLE: begin
          if (op_valid) begin
            op <= op_code;
            row <= op_row;
            len <= op_len;
            last <= op_last;
            step <= 6'd0;
            phase <= 1'b0;
            cnt <= '0;
            plane <= 2'd0;
            in_readout <= 1'b0;
            state <= S_PUT;
          end
        end
        S_PUT: begin
          phase <= ~phase;
          if (phase) begin
            if (need_len && cnt + 1'b1 < COUNT_W'(len) &&
                !(op == NTPIS_OP_ID && cnt + 1'b1 >= COUNT_W'(ID_BYTES))) begin
              cnt <= cnt + 1'b1;
            end else if (in_readout) begin
              cnt <= '0;
              if (rd_kind == K_READ) begin
                if (plane[0]) begin
                  state <= S_DONE;
                end else begin
                  plane <= 2'd1;
                  step <= 6'd0;
                end
              end else begin
                step <= step + 6'd1;
              end
            end else if (seq_end) begin
              cnt <= '0;
              state <= (busy_after) ? S_WAIT : S_DONE;
              wait_seen <= 1'b0;
              wait_cnt <= '0;
            end else begin
              cnt <= '0;
              if (step == 6'd3 && (op == NTPIS_OP_ERASE2 ||
                  op == NTPIS_OP_READ2 || op == NTPIS_OP_CACHE2)) begin
                plane <= 2'd1;
              end
              step <= step + 6'd1;
            end
            // ID stays on its read step for all ten bytes
            if (kind == K_READ && op == NTPIS_OP_ID) begin
              cnt <= (cnt + 1'b1 < COUNT_W'(ID_BYTES)) ? cnt + 1'b1 : cnt;
              if (cnt + 1'b1 >= COUNT_W'(ID_BYTES)) begin
                state <= S_DONE;
              end else begin
                state <= S_PUT;
              end
            end
          end
        end
        S_WAIT: begin
          // wait until busy line returns high
          wait_cnt <= wait_cnt + 1'b1;
          if (!ready_busy_n) begin
            wait_seen <= 1'b1;
          end
          if (ready_busy_n && (wait_seen || wait_cnt > COUNT_W'(WB_CYC))) begin
            if ((op == NTPIS_OP_PROG2 || op == NTPIS_OP_COPY2) &&
                !plane[0]) begin
              plane <= 2'd1;
              step <= 6'd0;
              state <= S_PUT;
            end else if (op == NTPIS_OP_CACHE2 && step == 6'd8) begin
              // Pages sit in the data registers; move them to the caches
              step <= 6'd9;
              state <= S_PUT;
            end else if (op == NTPIS_OP_READ2 || op == NTPIS_OP_CACHE2) begin
              plane <= 2'd0;
              step <= 6'd0;
              in_readout <= 1'b1;
              state <= S_PUT;
            end else begin
              op <= NTPIS_OP_STATUS;
              step <= 6'd0;
              len <= 16'h0001;
              state <= S_PUT;
            end
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Pin drive from the current step
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      chip_en_n <= 1'b1;
      cmd_latch <= 1'b0;
      addr_latch <= 1'b0;
      write_strobe_n <= 1'b1;
      read_strobe_n <= 1'b1;
      io_out <= 8'h00;
      io_oe <= 1'b0;
    end else begin
      chip_en_n <= !(state == S_PUT || state == S_WAIT);
      cmd_latch <= (state == S_PUT) && (cur_kind == K_CMD);
      addr_latch <= (state == S_PUT) && (cur_kind == K_ADDR);
      write_strobe_n <= !((state == S_PUT) && !phase &&
                          (cur_kind != K_READ));
      read_strobe_n <= !((state == S_PUT) && !phase &&
                         (cur_kind == K_READ));
      io_out <= (cur_kind == K_DATA) ? wr_data : cur_code;
      io_oe <= (state == S_PUT) && (cur_kind != K_READ);
    end
  end

  // ==========================================================
  // Read capture, ID fields and result
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
      rd_index <= 4'h0;
      op_done <= 1'b0;
      op_fail <= 1'b0;
      id_byte3 <= 8'h00;
      id_byte4 <= 8'h00;
      id_byte5 <= 8'h00;
      id_byte6 <= 8'h00;
    end else begin
      rd_valid <= (state == S_PUT) && phase && (cur_kind == K_READ);
      op_done <= (state == S_DONE);
      if ((state == S_PUT) && phase && (cur_kind == K_READ)) begin
        rd_data <= io_in;
        rd_index <= cnt[3:0];
        // ID bytes 3 to 6 kept by position
        if (op == NTPIS_OP_ID) begin
          case (cnt[3:0])
            4'd2: id_byte3 <= io_in;
            4'd3: id_byte4 <= io_in;
            4'd4: id_byte5 <= io_in;
            4'd5: id_byte6 <= io_in;
            default: id_byte3 <= id_byte3;
          endcase
        end
        if (op == NTPIS_OP_STATUS) begin
          op_fail <= io_in[ST_FAIL_BIT];
        end
      end
    end
  end

  // Strobe and drive are exclusive by design; a clash would fight the bus
  drive_excl_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    !(io_oe && !read_strobe_n))
    else $error("bus driven during read strobe");
  // no commands sent while device is busy
  busy_quiet_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (state == S_WAIT) |-> write_strobe_n || $past(state) == S_PUT)
    else $error("strobe during busy wait");
  // a busy device keeps the host waiting
  busy_hold_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (state == S_WAIT && !ready_busy_n) |=> state == S_WAIT)
    else $error("left busy wait while device busy");
  // 11h is followed by the plane-1 81h
  prog_pair_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (state == S_PUT && op == NTPIS_OP_PROG2 && step == 6'd0 && plane[0])
    |-> cur_code == CMD_PROG2)
    else $error("second plane not opened with 81h");
  // the 10h confirm only ever closes the second plane
  prog_conf_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (cmd_latch && !write_strobe_n && io_out == CMD_PCONF) |-> plane[0])
    else $error("10h sent for the first plane");
  // first row byte on the pins carries its half's plane bit
  row_plane_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (addr_latch && !write_strobe_n && $past(step) == 6'd3 &&
     $past(op) == NTPIS_OP_PROG2) |-> io_out[7] == plane[0])
    else $error("row byte plane bit wrong");
  // cache step code follows the last-pages flag
  cache_end_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (cmd_latch && !write_strobe_n &&
     (io_out == CMD_CACHE_END || io_out == CMD_CACHE_NEXT))
    |-> (io_out == CMD_CACHE_END) == last)
    else $error("wrong cache step code");
endmodule // ntpis_host
`default_nettype wire

// File: testbench/ntpis_dev_model.sv
/*
  Behavioural model of the two-plane NAND device for the host bench.
  Assumes pins move on ref_clk edges, one clock per strobe phase.
*/
`timescale 1ns/100ps
`default_nettype none
module ntpis_dev_model #(
  parameter int PROG_CYC = 40
) (
  input wire logic ref_clk,
  input wire logic chip_en_n,
  input wire logic cmd_latch,
  input wire logic addr_latch,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic [7:0] io_out,
  output logic [7:0] io_in,
  output logic ready_busy_n,
  input wire logic log_clr,
  input wire logic fail_flag
);
  import ntpis_pkg::*;
  // ========================================
  // Identification table, maker values are arbitrary
  // ten bytes, field layout
  localparam logic [7:0] ID_TAB [10] = '{8'hA5, 8'h3C,
    {1'b1, 1'b0, 2'b01, 2'b00, 2'b01}, {1'b0, 1'b0, 2'b10, 2'b01, 2'b10},
    {1'b0, 3'b010, 2'b01, 2'b00}, {1'b0, 1'b1, 3'b000, 3'b001},
    8'h5A, 8'h5A, 8'h5A, 8'h5A};
  logic [7:0] cmd_log [0:15];
  logic [7:0] addr_log [0:31];
  logic [7:0] data_log [0:63];
  int cmd_n = 0, addr_n = 0, data_n = 0, acnt = 0, ridx = 0, busy = 0;
  logic [7:0] cmd = 8'h00, rd_val, last_val = 8'h00;
  logic plane = 1'b0;
  // status bit 6 ready, bit 0 fail
  always_comb begin
    if (cmd == CMD_STATUS)
      rd_val = {1'b1, ready_busy_n, ready_busy_n, 4'h0, fail_flag};
    else if (cmd == CMD_IDREAD)
      rd_val = ID_TAB[ridx % 10];
    else
      rd_val = {plane, 1'b1, ridx[5:0]};
  end
  // Released bus shows the inverse, so a stale sample cannot pass
  assign io_in = read_strobe_n ? ~last_val : rd_val;
  assign ready_busy_n = (busy == 0);
  // Latch bytes at the edge that ends each strobe-low phase
  always @(posedge ref_clk) begin
    if (busy > 0)
      busy <= busy - 1;
    if (log_clr) begin
      cmd_n <= 0;
      addr_n <= 0;
      data_n <= 0;
    end else if (!chip_en_n && !write_strobe_n) begin
      if (cmd_latch) begin
        cmd <= io_out;
        cmd_log[cmd_n] <= io_out;
        cmd_n <= cmd_n + 1;
        acnt <= 0;
        ridx <= 0;
        // busy spans, both planes at once
        case (io_out)
          CMD_PDUMMY, CMD_RESET: busy <= 5;
          CMD_PCONF, CMD_ERASE2: busy <= PROG_CYC;
          CMD_READ2, CMD_CACHE_LOAD: busy <= ARRAY_READ_CYC - 10;
          CMD_CACHE_NEXT, CMD_CACHE_END: busy <= CACHE_BUSY_CYC - 10;
          default: ;
        endcase
      end else if (addr_latch) begin
        addr_log[addr_n] <= io_out;
        addr_n <= addr_n + 1;
        acnt <= acnt + 1;
        if (cmd == CMD_READ1 && acnt == 2)
          plane <= io_out[7];
      end else begin
        // plane page registers, kept as one flat log
        data_log[data_n] <= io_out;
        data_n <= data_n + 1;
      end
    end else if (!chip_en_n && !read_strobe_n) begin
      last_val <= rd_val;
      ridx <= ridx + 1;
    end
  end
endmodule // ntpis_dev_model
`default_nettype wire

// File: testbench/tb_ntpis_host.sv
/*
  Self-checking bench for ntpis_host against the device model.
  Assumes the model sits directly on the host's device pins.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_ntpis_host;
  import ntpis_pkg::*;
  logic ref_clk = 1'b0, reset_n = 1'b0, op_valid = 1'b0, op_last = 1'b1;
  ntpis_op_t op_code = NTPIS_OP_STATUS;
  logic [23:0] op_row = 24'h01_2300;
  logic [15:0] op_len = 16'h0000;
  logic [7:0] wr_data = 8'h00, rd_data, io_out, io_in;
  logic [7:0] id_byte3, id_byte4, id_byte5, id_byte6;
  logic [3:0] rd_index;
  logic op_ready, wr_take, rd_valid, op_done, op_fail, chip_en_n, cmd_latch;
  logic addr_latch, write_strobe_n, read_strobe_n, io_oe, ready_busy_n;
  logic log_clr = 1'b0, fail_flag = 1'b0, took = 1'b0;
  logic [7:0] rx [0:31];
  int rx_n = 0, err_total = 0, samples_checked = 0;
  localparam logic [7:0] EXP_ID [10] = '{8'hA5, 8'h3C, 8'h91, 8'h26,
    8'h24, 8'h41, 8'h5A, 8'h5A, 8'h5A, 8'h5A};
  ntpis_host uut (.ref_clk(ref_clk), .reset_n(reset_n),
    .op_valid(op_valid), .op_code(op_code), .op_row(op_row),
    .op_len(op_len), .op_last(op_last), .op_ready(op_ready),
    .wr_data(wr_data), .wr_take(wr_take), .rd_data(rd_data),
    .rd_valid(rd_valid), .rd_index(rd_index), .op_done(op_done),
    .op_fail(op_fail), .id_byte3(id_byte3), .id_byte4(id_byte4),
    .id_byte5(id_byte5), .id_byte6(id_byte6), .chip_en_n(chip_en_n),
    .cmd_latch(cmd_latch), .addr_latch(addr_latch),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
    .io_out(io_out), .io_oe(io_oe), .io_in(io_in),
    .ready_busy_n(ready_busy_n));
  ntpis_dev_model dev (.ref_clk(ref_clk), .chip_en_n(chip_en_n),
    .cmd_latch(cmd_latch), .addr_latch(addr_latch),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
    .io_out(io_out), .io_in(io_in), .ready_busy_n(ready_busy_n),
    .log_clr(log_clr), .fail_flag(fail_flag));
  // ========================================
  // Clock and user-side byte handling
  always #50 ref_clk = ~ref_clk;
  // Byte source steps only after the host has consumed a byte
  always @(negedge ref_clk) begin
    if (log_clr) begin
      wr_data <= 8'h00;
      took <= 1'b0;
      rx_n <= 0;
    end else begin
      if (took)
        wr_data <= wr_data + 8'h01;
      took <= wr_take;
      if (rd_valid === 1'b1) begin
        rx[rx_n] <= rd_data;
        rx_n <= rx_n + 1;
      end
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One operation: request, bounded wait, command sequence check
  task automatic run(input ntpis_op_t op, input logic [15:0] len,
      input int n, input logic [95:0] seq);
    int i;
    @(negedge ref_clk);
    log_clr <= 1'b1;
    @(negedge ref_clk);
    log_clr <= 1'b0;
    chk({7'h00, op_ready}, 8'h01);
    op_code <= op;
    op_len <= len;
    op_valid <= 1'b1;
    @(negedge ref_clk);
    op_valid <= 1'b0;
    i = 0;
    while (op_done !== 1'b1 && i < 4000) begin
      @(negedge ref_clk);
      i++;
    end
    chk({7'h00, op_done}, 8'h01);
    // Done only once the device is ready
    chk({7'h00, ready_busy_n}, 8'h01);
    for (i = 0; i < n; i++)
      chk(dev.cmd_log[i], seq[8*(n-1-i) +: 8]);
    @(negedge ref_clk);
  endtask
  task automatic finish_test();
    $display("checks=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ========================================
  // Watchdog, well beyond the expected run of some 2000 cycles
  initial begin
    #3000000;
    err_total++;
    finish_test();
  end
  // ========================================
  // Test sequence
  initial begin
    int i;
    repeat (5) @(negedge ref_clk);
    chk({chip_en_n, io_oe, write_strobe_n, read_strobe_n, 4'h0}, 8'hB0);
    reset_n <= 1'b1;
    run(NTPIS_OP_ID, 16'h0000, 1, 96'h90);
    chk(8'(rx_n), 8'h0A);
    chk({4'h0, rd_index}, 8'h09);
    for (i = 0; i < 10; i++)
      chk(rx[i], EXP_ID[i]);
    chk(id_byte3, 8'h91);
    chk(id_byte4, 8'h26);
    chk(id_byte5, 8'h24);
    chk(id_byte6, 8'h41);
    run(NTPIS_OP_STATUS, 16'h0000, 1, 96'h70);
    chk(rx[0], 8'hE0);
    chk({7'h00, op_fail}, 8'h00);
    // Program with a failing device, then copy-back passing
    fail_flag <= 1'b1;
    run(NTPIS_OP_PROG2, 16'h0004, 5, 96'h80_1181_1070);
    chk({7'h00, op_fail}, 8'h01);
    chk(dev.addr_log[2] ^ dev.addr_log[7], 8'h80);
    chk(dev.addr_log[3] ^ dev.addr_log[8], 8'h00);
    chk(8'(dev.data_n), 8'h08);
    for (i = 0; i < 8; i++)
      chk(dev.data_log[i], 8'(i));
    fail_flag <= 1'b0;
    run(NTPIS_OP_COPY2, 16'h0002, 5, 96'h80_1181_1070);
    chk(dev.addr_log[2] ^ dev.addr_log[7], 8'h80);
    chk({7'h00, op_fail}, 8'h00);
    run(NTPIS_OP_ERASE2, 16'h0000, 4, 96'h6060_D070);
    chk(dev.addr_log[0] ^ dev.addr_log[3], 8'h80);
    run(NTPIS_OP_READ2, 16'h0003, 9, 96'h60_6030_0005_E000_05E0);
    chk(8'(rx_n), 8'h06);
    for (i = 0; i < 6; i++)
      chk(rx[i], {i >= 3, 1'b1, 6'(i % 3)});
    chk(dev.addr_log[1] ^ dev.addr_log[4], 8'h00);
    // Last-pages cache read, then a continuing one
    run(NTPIS_OP_CACHE2, 16'h0002, 10, 96'h6060_333F_0005_E000_05E0);
    chk(rx[3], 8'hC1);
    op_last <= 1'b0;
    run(NTPIS_OP_CACHE2, 16'h0001, 10, 96'h6060_3331_0005_E000_05E0);
    chk(8'(rx_n), 8'h02);
    chk(rx[1], 8'hC0);
    run(NTPIS_OP_RESET, 16'h0000, 1, 96'hFF);
    finish_test();
  end
endmodule // tb_ntpis_host
`default_nettype wire
